// ==== core/spfp_hex.v ====
// hex ascii digit to nibble and back
`timescale 1ns/100ps
`default_nettype none
module spfp_hex (
    input  wire [7:0] char_i,
    input  wire [3:0] nib_i,
    output wire [3:0] nib_o,
    output wire       ok_o,
    output wire [7:0] char_o
);
    wire is_dig = (char_i >= 8'h30) && (char_i <= 8'h39);
    wire is_lo  = (char_i >= 8'h61) && (char_i <= 8'h66);
    wire is_up  = (char_i >= 8'h41) && (char_i <= 8'h46);
    wire [7:0] dig_off = char_i - 8'h30;
    wire [7:0] lo_off  = char_i - 8'h57;
    wire [7:0] up_off  = char_i - 8'h37;
    assign ok_o   = is_dig | is_lo | is_up;
    assign nib_o  = is_dig ? dig_off[3:0] : (is_lo ? lo_off[3:0] : up_off[3:0]);
    assign char_o = (nib_i < 4'hA) ? {4'h3, nib_i} : (8'h57 + {4'h0, nib_i});
endmodule
`default_nettype wire

// ==== core/spfp_regs.vh ====
// constants of the sensor programmer frame parser
`ifndef SPFP_REGS_VH
`define SPFP_REGS_VH
`define SPFP_ADDR_CTRL      8'h00
`define SPFP_ADDR_STATUS    8'h04
`define SPFP_ADDR_IRQ_STAT  8'h08
`define SPFP_ADDR_IRQ_EN    8'h0C
`define SPFP_ADDR_IRQ_CLR   8'h10
`define SPFP_ADDR_CMD       8'h14
`define SPFP_ADDR_TEL_DATA  8'h18
`define SPFP_ADDR_REPLY     8'h1C
`define SPFP_CHAR_START     8'h02
`define SPFP_CHAR_END       8'h03
`define SPFP_MODE_SINGLE    4'h2
`define SPFP_MODE_RST       4'h0
`define SPFP_REPLY_LEN      4'h8
`define SPFP_IRQ_FRAME      0
`define SPFP_IRQ_DISCARD    1
`define SPFP_IRQ_REPLY      2
`define SPFP_IRQ_MODE       3
`endif

// ==== core/spfp_top.v ====
// framed ascii command interpreter with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none
`include "spfp_regs.vh"
module spfp_top (
    input  wire        CLK_SYS_I,
    input  wire        RST_B_I,
    input  wire        RX_VALID_I,
    input  wire [7:0]  RX_CHAR_I,
    input  wire        TX_READY_I,
    output reg         TX_VALID_O,
    output reg  [7:0]  TX_CHAR_O,
    output reg         TEL_VALID_O,
    output reg  [7:0]  TEL_LETTER_O,
    output reg  [15:0] TEL_HDR_O,
    output reg  [15:0] TEL_DATA_O,
    input  wire        TEL_DONE_I,
    input  wire        TEL_FLAG_I,
    input  wire [15:0] TEL_RESULT_I,
    output reg         IRQ_O,
    input  wire [31:0] S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [31:0] S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_BODY = 3'd1;
    localparam [2:0] ST_WAIT = 3'd2;
    localparam [2:0] ST_SEND = 3'd3;

    reg  [2:0]  st_q;
    reg  [7:0]  letter_q;
    reg  [3:0]  cnt_q;
    reg  [3:0]  need_q;
    reg  [7:0]  field_q [0:9];
    reg  [3:0]  mode_q;
    reg         en_q;
    reg  [3:0]  irq_en_q;
    reg  [3:0]  irq_st_q;
    reg  [7:0]  reply_q [0:7];
    reg  [3:0]  tx_idx_q;
    reg  [15:0] last_res_q;
    reg         last_flag_q;
    reg  [3:0]  ev;
    wire [3:0]  clr;
    integer     i;

    ////////////////////////////////////////////////////////////////////////
    // hex conversion: decode data characters, encode reply nibbles
    wire [3:0] nb0, nb1, nb2, nb3, nbm;
    wire       ok0, ok1, ok2, ok3, okm;
    wire [7:0] hx0, hx1, hx2, hx3, hxf;
    spfp_hex u_h0 (.char_i(field_q[4]), .nib_i(TEL_RESULT_I[15:12]), .nib_o(nb0), .ok_o(ok0), .char_o(hx0));
    spfp_hex u_h1 (.char_i(field_q[5]), .nib_i(TEL_RESULT_I[11:8]), .nib_o(nb1), .ok_o(ok1), .char_o(hx1));
    spfp_hex u_h2 (.char_i(field_q[6]), .nib_i(TEL_RESULT_I[7:4]), .nib_o(nb2), .ok_o(ok2), .char_o(hx2));
    spfp_hex u_h3 (.char_i(field_q[7]), .nib_i(TEL_RESULT_I[3:0]), .nib_o(nb3), .ok_o(ok3), .char_o(hx3));
    spfp_hex u_hm (.char_i(field_q[0]), .nib_i({3'h0, TEL_FLAG_I}), .nib_o(nbm), .ok_o(okm), .char_o(hxf));
    wire       par = ^TEL_RESULT_I;

    // parameter characters each letter requires
    function [3:0] need_of(input [7:0] c);
        begin
            case (c)
                8'h65: need_of = 4'd9;            // write
                8'h71: need_of = 4'd4;            // read
                8'h63: need_of = 4'd12 - 4'd2;    // program, capped to ten stored
                8'h6B: need_of = 4'd8;
                8'h6A, 8'h6D, 8'h68: need_of = 4'd1;
                8'h6E, 8'h6F, 8'h74, 8'h76, 8'h69: need_of = 4'd0;
                8'h7A, 8'h75, 8'h79: need_of = 4'd1;
                default: need_of = 4'hF;
            endcase
        end
    endfunction
    wire [3:0] need_in = need_of(RX_CHAR_I);
    wire       sensor_cmd = (letter_q == 8'h65) | (letter_q == 8'h71) |
                            (letter_q == 8'h63) | (letter_q == 8'h6B);
    wire       echo_cmd = (letter_q == 8'h65) | (letter_q == 8'h71) |
                          (letter_q == 8'h6D) | (letter_q == 8'h74);

    ////////////////////////////////////////////////////////////////////////
    // frame parser and reply sender
    always @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q <= ST_IDLE;
            letter_q <= 8'h00;
            cnt_q <= 4'h0;
            need_q <= 4'h0;
            mode_q <= `SPFP_MODE_RST;
            tx_idx_q <= 4'h0;
            TX_VALID_O <= 1'b0;
            TX_CHAR_O <= 8'h00;
            TEL_VALID_O <= 1'b0;
            TEL_LETTER_O <= 8'h00;
            TEL_HDR_O <= 16'h0000;
            TEL_DATA_O <= 16'h0000;
            last_res_q <= 16'h0000;
            last_flag_q <= 1'b0;
            ev <= 4'h0;
            for (i = 0; i < 10; i = i + 1) field_q[i] <= 8'h00;
            for (i = 0; i < 8; i = i + 1) reply_q[i] <= 8'h00;
        end else begin
            ev <= 4'h0;
            TEL_VALID_O <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (en_q && RX_VALID_I && RX_CHAR_I == `SPFP_CHAR_START) begin
                        st_q <= ST_BODY;
                        cnt_q <= 4'h0;
                        letter_q <= 8'h00;
                    end
                end
                ST_BODY: begin
                    if (RX_VALID_I) begin
                        if (RX_CHAR_I == `SPFP_CHAR_START) begin
                            cnt_q <= 4'h0;
                            letter_q <= 8'h00;
                            ev[`SPFP_IRQ_DISCARD] <= 1'b1;
                        end else if (letter_q == 8'h00) begin
                            if (need_in == 4'hF) begin
                                st_q <= ST_IDLE;
                                ev[`SPFP_IRQ_DISCARD] <= 1'b1;
                            end else begin
                                letter_q <= RX_CHAR_I;
                                need_q <= need_in;
                            end
                        end else if (cnt_q == need_q) begin
                            if (RX_CHAR_I == `SPFP_CHAR_END) begin
                                ev[`SPFP_IRQ_FRAME] <= 1'b1;
                                if (letter_q == 8'h6A && okm) begin
                                    mode_q <= nbm;
                                    ev[`SPFP_IRQ_MODE] <= (nbm == `SPFP_MODE_SINGLE);
                                end
                                if (sensor_cmd) begin
                                    TEL_VALID_O <= 1'b1;
                                    TEL_LETTER_O <= letter_q;
                                    TEL_HDR_O <= {field_q[0][3:0], field_q[1][3:0],
                                                  field_q[2][3:0], field_q[3][3:0]};
                                    TEL_DATA_O <= {nb0, nb1, nb2, nb3};
                                end
                                st_q <= (sensor_cmd || echo_cmd) ? ST_WAIT : ST_IDLE;
                            end else begin
                                st_q <= ST_IDLE;
                                ev[`SPFP_IRQ_DISCARD] <= 1'b1;
                            end
                        end else begin
                            if (cnt_q < 4'd10) field_q[cnt_q] <= RX_CHAR_I;
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (TEL_DONE_I || !sensor_cmd) begin
                        last_res_q <= TEL_RESULT_I;
                        last_flag_q <= TEL_FLAG_I;
                        if (echo_cmd) begin
                            reply_q[0] <= `SPFP_CHAR_START;
                            reply_q[1] <= hxf;
                            reply_q[2] <= hx0;
                            reply_q[3] <= hx1;
                            reply_q[4] <= hx2;
                            reply_q[5] <= hx3;
                            reply_q[6] <= {7'h18, par};
                            reply_q[7] <= `SPFP_CHAR_END;
                            tx_idx_q <= 4'h0;
                            st_q <= ST_SEND;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_SEND: begin
                    if (TX_VALID_O && TX_READY_I) begin
                        TX_VALID_O <= 1'b0;
                        if (tx_idx_q == `SPFP_REPLY_LEN - 4'h1) begin
                            st_q <= ST_IDLE;
                            ev[`SPFP_IRQ_REPLY] <= 1'b1;
                        end
                        tx_idx_q <= tx_idx_q + 4'h1;
                    end else if (!TX_VALID_O) begin
                        TX_VALID_O <= 1'b1;
                        TX_CHAR_O <= reply_q[tx_idx_q[2:0]];
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    reg        aw_q, w_q;
    reg [7:0]  awa_q;
    reg [31:0] wd_q;
    // write-one-clear strobe, only in the cycle the write is executed
    assign clr = (aw_q && w_q && !S_AXI_BVALID && awa_q == `SPFP_ADDR_IRQ_CLR) ?
                 wd_q[3:0] : 4'h0;
    always @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= 2'b00;
            S_AXI_RDATA <= 32'h0;
            en_q <= 1'b1;
            irq_en_q <= 4'h0;
            irq_st_q <= 4'h0;
            IRQ_O <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && S_AXI_AWVALID && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_q && !S_AXI_WREADY && S_AXI_WVALID && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_q <= 1'b1;
                awa_q <= S_AXI_AWADDR[7:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_q <= 1'b1;
                wd_q <= S_AXI_WDATA;
            end
            if (aw_q && w_q && !S_AXI_BVALID) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= 2'b00;
                if (awa_q == `SPFP_ADDR_CTRL) begin
                    en_q <= wd_q[0];
                end else if (awa_q == `SPFP_ADDR_IRQ_EN) begin
                    irq_en_q <= wd_q[3:0];
                end else if (awa_q == `SPFP_ADDR_IRQ_CLR) begin
                    S_AXI_BRESP <= 2'b00;
                end else begin
                    S_AXI_BRESP <= 2'b10;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            irq_st_q <= (irq_st_q & ~clr) | ev;
            IRQ_O <= |(((irq_st_q & ~clr) | ev) & irq_en_q);
            S_AXI_ARREADY <= !S_AXI_ARREADY && S_AXI_ARVALID && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_CTRL) begin
                    S_AXI_RDATA <= {31'h0, en_q};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_STATUS) begin
                    S_AXI_RDATA <= {25'h0, st_q, mode_q};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_IRQ_STAT) begin
                    S_AXI_RDATA <= {28'h0, irq_st_q};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_IRQ_EN) begin
                    S_AXI_RDATA <= {28'h0, irq_en_q};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_IRQ_CLR) begin
                    S_AXI_RDATA <= 32'h0;
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_CMD) begin
                    S_AXI_RDATA <= {24'h0, letter_q};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_TEL_DATA) begin
                    S_AXI_RDATA <= {16'h0, TEL_DATA_O};
                end else if (S_AXI_ARADDR[7:0] == `SPFP_ADDR_REPLY) begin
                    S_AXI_RDATA <= {15'h0, last_flag_q, last_res_q};
                end else begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= 2'b10;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/spfp_chk.sv ====
// assertion checker on the frame parser ports
`timescale 1ns/100ps
`default_nettype none
module spfp_chk (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_B_I,
    input wire logic        RX_VALID_I,
    input wire logic [7:0]  RX_CHAR_I,
    input wire logic        TX_READY_I,
    input wire logic        TX_VALID_O,
    input wire logic [7:0]  TX_CHAR_O,
    input wire logic        TEL_VALID_O,
    input wire logic [7:0]  TEL_LETTER_O,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RREADY
);
default clocking @(posedge CLK_SYS_I); endclocking
default disable iff (!RST_B_I);
// position of the next reply character
logic [2:0] cnt_q;
always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I)
        cnt_q <= 3'h0;
    else if (TX_VALID_O && TX_READY_I)
        cnt_q <= cnt_q + 3'h1;
end
sequence s_take;
    TX_VALID_O && TX_READY_I;
endsequence
sequence s_etx;
    RX_VALID_I && RX_CHAR_I == 8'h03;
endsequence
a_tx_hold_char: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_CHAR_O)) else $error("reply char not held");
a_tx_gap_after: assert property (s_take |=> !TX_VALID_O)
    else $error("reply valid not dropped");
a_reply_start: assert property (TX_VALID_O && cnt_q == 3'h0 |-> TX_CHAR_O == 8'h02)
    else $error("reply start char wrong");
a_reply_end: assert property (TX_VALID_O && cnt_q == 3'h7 |-> TX_CHAR_O == 8'h03)
    else $error("reply end char wrong");
a_reply_hex_digit: assert property (TX_VALID_O && cnt_q inside {[1:5]} |->
    TX_CHAR_O inside {[8'h30:8'h39], [8'h61:8'h66]}) else $error("reply digit not hex");
a_tel_one_pulse: assert property (TEL_VALID_O |=> !TEL_VALID_O)
    else $error("telegram pulse too long");
a_tel_sensor_ltr: assert property (TEL_VALID_O |->
    TEL_LETTER_O inside {8'h65, 8'h71, 8'h63, 8'h6B}) else $error("telegram letter wrong");
a_tel_after_end: assert property (TEL_VALID_O |-> $past(RX_VALID_I)
    && $past(RX_CHAR_I) == 8'h03) else $error("telegram without end char");
a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
a_rresp_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read response dropped");
c_frame_tel: cover property (s_etx ##1 TEL_VALID_O);
endmodule
bind spfp_top spfp_chk chk_u (.CLK_SYS_I, .RST_B_I, .RX_VALID_I, .RX_CHAR_I, .TX_READY_I,
    .TX_VALID_O, .TX_CHAR_O, .TEL_VALID_O, .TEL_LETTER_O, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_RVALID, .S_AXI_RDATA, .S_AXI_RREADY);
`default_nettype wire

// ==== dv/spfp_host.sv ====
// host pc model: sends frames, collects reply characters
`timescale 1ns/100ps
`default_nettype none
module spfp_host (
    input  wire logic       clk_i,
    output var  logic       rx_valid_o,
    output var  logic [7:0] rx_char_o,
    output var  logic       tx_ready_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_char_i
);
logic       slow = 1'b0;
logic [7:0] rsp_q[$];
initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'hFF;
    tx_ready_o = 1'b0;
end
// slow host stalls every other cycle
always @(posedge clk_i) begin
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    if (tx_valid_i && tx_ready_o)
        rsp_q.push_back(tx_char_i);
end
// caller frames the letter with exactly its groups
task automatic send(input string s);
    foreach (s[i]) begin
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_char_o <= s[i];
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_char_o <= ~s[i];
    end
endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench of the frame parser
`timescale 1ns/100ps
`default_nettype none
`include "spfp_regs.vh"
module tb;
typedef struct {string c; logic [15:0] res; logic f; logic [15:0] h; logic [15:0] d;} spfp_row_t;
logic        clk = 1'b0;
logic        rst_b = 1'b0;
logic        rxv, txr, txv, telv, irq, awr, wr, bv, arr, rv, tdone = 1'b0, tflg = 1'b0;
logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
logic [7:0]  rxc, txc, tltr, cap_l;
logic [15:0] thdr, tdat, cap_h, cap_d, tres = 16'h0000;
logic [31:0] awa = '0, wd = '0, ara = '0, rd;
logic [1:0]  br, rr;
int          err_total = 0, num_checks = 0, tel_n = 0, dly = 0, cyc = 0;
spfp_row_t   rows[4] = '{'{"q0121", 16'h01F0, 1'b0, 16'h0121, 16'h0000},
    '{"e31210a0f1", 16'hBEEF, 1'b1, 16'h3121, 16'h0A0F},
    '{"m3", 16'h1234, 1'b0, 16'h0000, 16'h0000}, '{"t", 16'hA5C3, 1'b1, 16'h0000, 16'h0000}};
always #2.5 clk = ~clk;
spfp_top dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b), .RX_VALID_I(rxv), .RX_CHAR_I(rxc),
    .TX_READY_I(txr), .TX_VALID_O(txv), .TX_CHAR_O(txc), .TEL_VALID_O(telv),
    .TEL_LETTER_O(tltr), .TEL_HDR_O(thdr), .TEL_DATA_O(tdat), .TEL_DONE_I(tdone),
    .TEL_FLAG_I(tflg), .TEL_RESULT_I(tres), .IRQ_O(irq), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
spfp_host host_u (.clk_i(clk), .rx_valid_o(rxv), .rx_char_o(rxc), .tx_ready_o(txr),
    .tx_valid_i(txv), .tx_char_i(txc));
////////////////////////////////////////////////////////////////////////////////
// telegram engine stand-in: answers four cycles after a request
always @(posedge clk) begin
    tdone <= 1'b0;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
        err_total++;
        complete_run();
    end
    if (telv) begin
        tel_n <= tel_n + 1;
        {cap_l, cap_h, cap_d} <= {tltr, thdr, tdat};
        dly <= 4;
    end else if (dly > 0) begin
        dly <= dly - 1;
        tdone <= (dly == 1);
    end
end
////////////////////////////////////////////////////////////////////////////////
task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
        err_total++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h57 + n;
endfunction
task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {awa, wd, awv, wv} <= {a, d, 2'b11};
    do begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wr) wv <= 1'b0;
        if (bv) bre <= 1'b1;
    end while (!(bv && bre));
    r = br;
    bre <= 1'b0;
endtask
task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {ara, arv} <= {a, 1'b1};
    do begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
        if (rv) rre <= 1'b1;
    end while (!(rv && rre));
    {d, r} = {rd, rr};
    rre <= 1'b0;
endtask
// host reads the whole reply before its next command
task automatic wait8;
    for (int k = 0; k < 400 && host_u.rsp_q.size() < 8; k++) @(posedge clk);
endtask
task automatic regs_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk({txv, telv, irq}, 32'h0);
    axi_rd(`SPFP_ADDR_CTRL, d, r);
    chk(d, 32'h1);
    axi_rd(`SPFP_ADDR_IRQ_EN, d, r);
    chk(d, 32'h0);
    axi_rd(`SPFP_ADDR_STATUS, d, r);
    chk(d[3:0], `SPFP_MODE_RST);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  e[8];
    logic [15:0] v;
    int          n0;
    string       seq[5] = '{"e31F0080F0", "h1", "q0121", "e312120001", "k40600130"};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    regs_reset();
    foreach (rows[i]) begin
        {host_u.slow, tres, tflg, v} <= {i[0], rows[i].res, rows[i].f, rows[i].res};
        n0 = tel_n;
        host_u.rsp_q.delete();
        host_u.send({"\002", rows[i].c, "\003"});
        wait8();
        e = '{8'h02, hx({3'h0, rows[i].f}), hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0]),
            8'h30 | {7'h0, ^v}, 8'h03};
        for (int k = 0; k < 8; k++) chk(host_u.rsp_q[k], e[k]);
        chk(tel_n - n0, (rows[i].c[0] inside {"e", "q"}) ? 1 : 0);
        if (tel_n != n0) chk({cap_l, cap_h}, {rows[i].c[0], rows[i].h});
        if (rows[i].c[0] == "e") chk(cap_d, rows[i].d);
    end
    axi_wr(`SPFP_ADDR_IRQ_CLR, 32'hF, r);
    host_u.send("\002j2\003");
    repeat (8) @(posedge clk);
    axi_rd(`SPFP_ADDR_STATUS, d, r);
    chk(d[3:0], `SPFP_MODE_SINGLE);
    axi_rd(`SPFP_ADDR_IRQ_STAT, d, r);
    chk(d[3:0], 4'h9);
    axi_wr(`SPFP_ADDR_IRQ_EN, 32'h8, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    axi_wr(`SPFP_ADDR_IRQ_EN, 32'h0, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    axi_wr(`SPFP_ADDR_IRQ_EN, 32'h8, r);
    axi_wr(`SPFP_ADDR_IRQ_CLR, 32'hF, r);
    repeat (3) @(posedge clk);
    axi_rd(`SPFP_ADDR_IRQ_STAT, d, r);
    chk({irq, d[30:0]}, 32'h0);
    n0 = tel_n;
    host_u.rsp_q.delete();
    host_u.send("\002x\003");
    host_u.send("\002q01215");
    repeat (20) @(posedge clk);
    chk(tel_n - n0 + host_u.rsp_q.size(), 0);
    axi_rd(`SPFP_ADDR_IRQ_STAT, d, r);
    chk(d[1:0], 2'h2);
    host_u.send("\002q0\002q0121\003");
    wait8();
    chk({16'(tel_n - n0), host_u.rsp_q[0], host_u.rsp_q[7]}, {16'h1, 16'h0203});
    // host-side ordering: deactivate, select, dummy read, calibrate, store
    foreach (seq[k]) begin
        host_u.rsp_q.delete();
        n0 = tel_n;
        host_u.send({"\002", seq[k], "\003"});
        if (seq[k][0] inside {"e", "q"}) wait8();
        else repeat (12) @(posedge clk);
        chk(tel_n - n0, (seq[k][0] inside {"e", "q", "k"}) ? 1 : 0);
    end
    axi_wr(32'h40, 32'h1, r);
    chk(r, 2'h2);
    axi_rd(32'h40, d, r);
    chk(r, 2'h2);
    chk(d, 32'h0);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    regs_reset();
    complete_run();
end
endmodule
`default_nettype wire
